//--- pix_expander.sv
module pix_expander
    import pix_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // link to the core
    pix_if.expander link,
    // named peripheral sources
    input wire logic [7:0] conversion_done_irq,
    input wire logic [5:0] dma_channel_irq,
    input wire logic [3:0] interproc_channel_irq,
    input wire logic ram_single_error_irq,
    input wire logic flash_single_error_irq,
    input wire logic fpu_overflow_flag,
    input wire logic fpu_underflow_flag,
    // all other wired sources by slot, unwired bits ignored
    input wire logic [NSRC-1:0] other_irq,
    // sources that bypass the expander
    input wire logic timer_one_irq,
    input wire logic timer_two_irq,
    input wire logic direct_nmi_irq,
    output logic timer_one_out,
    output logic timer_two_out,
    output logic direct_nmi_out
);
    import pix_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [NSRC-1:0] flag;       // pending flags
        logic [NGRP-1:0] busy;       // group taken, awaiting ack
        logic [NGRP-1:0] req;        // group lines
        pix_fetch_t fst;             // fetch sequencer
        logic [3:0] cnt;             // fetch cycle count
        logic [IDX_W-1:0] sel;       // slot being fetched
        logic ack;
        logic [IDX_W-1:0] idx;
        logic [VEC_W-1:0] vec;
        logic [2:0] byp;             // bypassed lines
    } pix_exp_t;

    pix_exp_t st_r;
    pix_exp_t st_nxt;
    logic [VEC_W-1:0] vec_ram [NSRC]; // software vector table
    logic [NSRC-1:0] src;
    logic [VEC_W-1:0] ram_q;

    // ****************************************
    // source assembly
    // ****************************************
    // reserved slots carry no peripheral
    always_comb begin
        src = other_irq & WIRED_MASK;
        src[SLOT_CONV_FIRST +: 8] = conversion_done_irq;
        src[SLOT_DMA_FIRST +: 6] = dma_channel_irq;
        src[SLOT_IPC_FIRST +: 4] = interproc_channel_irq;
        src[SLOT_RAM_ERR] = ram_single_error_irq;
        src[SLOT_FLASH_ERR] = flash_single_error_irq;
        src[SLOT_FPU_OVF] = fpu_overflow_flag;
        src[SLOT_FPU_UNF] = fpu_underflow_flag;
    end

    // ram written by software, read at fetch time
    always_ff @(posedge sys_clk) begin
        if (link.vec_wr) begin
            vec_ram[link.vec_wr_idx] <= link.vec_wr_data;
        end
        ram_q <= vec_ram[st_r.sel];
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [NSRC-1:0] live;
        logic [7:0] gpend;
        st_nxt = st_r;
        live = '0;
        gpend = '0;
        st_nxt.ack = 1'b0;
        // new events set flags; set beats the fetch clear below
        // hazard: only the served bit is cleared, others stay pending
        if (st_r.fst == PIX_DONE) begin
            st_nxt.flag[st_r.sel] = 1'b0;
        end
        st_nxt.flag = st_nxt.flag | src;
        if (link.sw_flag_set) begin
            st_nxt.flag[link.sw_flag_idx] = 1'b1;
        end
        // group ack releases the block
        st_nxt.busy = st_r.busy & ~link.grp_ack;
        // enable gates each flag onto its group line
        live = st_r.flag & link.sw_enable;
        for (int g = 0; g < NGRP; g++) begin
            st_nxt.req[g] = |live[g*NPOS +: NPOS] & ~st_nxt.busy[g];
        end
        unique case (st_r.fst)
            PIX_IDLE: begin
                // core picks lowest line; within it lowest position
                if (link.fetch_req && link.fetch_grp < 4'(NGRP)) begin
                    gpend = live[link.fetch_grp*NPOS +: NPOS];
                    if (gpend != 8'h00 && !st_r.busy[link.fetch_grp]) begin
                        for (int p = NPOS - 1; p >= 0; p--) begin
                            if (gpend[p]) begin
                                st_nxt.sel = IDX_W'(link.fetch_grp * NPOS + p);
                            end
                        end
                        st_nxt.busy[link.fetch_grp] = 1'b1;
                        st_nxt.req[link.fetch_grp] = 1'b0;
                        st_nxt.cnt = 4'h0;
                        st_nxt.fst = PIX_WAIT;
                    end
                end
            end
            PIX_WAIT: begin
                // done state eight cycles after the request, vector returned on the ninth
                st_nxt.cnt = st_r.cnt + 4'h1;
                if (st_r.cnt == FETCH_LAST - 4'h1) begin
                    st_nxt.fst = PIX_DONE;
                end
            end
            PIX_DONE: begin
                st_nxt.ack = 1'b1;
                st_nxt.idx = st_r.sel;
                st_nxt.vec = ram_q;
                st_nxt.fst = PIX_IDLE;
            end
            default: st_nxt.fst = PIX_IDLE;
        endcase
        // direct lines skip grouping
        st_nxt.byp = {direct_nmi_irq, timer_two_irq, timer_one_irq};
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.group_request_vector = st_r.req;
    assign link.fetch_ack = st_r.ack;
    assign link.fetch_idx = st_r.idx;
    assign link.fetch_vec = st_r.vec;
    assign timer_one_out = st_r.byp[0];
    assign timer_two_out = st_r.byp[1];
    assign direct_nmi_out = st_r.byp[2];
endmodule

//--- pix_pkg.sv
// Operation
// - 96 inputs, twelve groups, twelve cpu lines
// - each group holds eight pending flags
// - only 66 positions wired, rest reserved
// - one writable vector word per input
// - vector supplied within eight clock cycles; the expander returns it nine cycles after the request
// - per-input enable gates group request
// - fixed hardware order plus software masks
// - software interrupt only on reserved, idle group; the expander sets the flag at any sw_flag_idx
// - avoid flag read-modify-write with live sources
// - software interrupts safe only in quiet groups
// - six dma channels, own input each
// - single-bit memory errors maskable, others nmi
// - four interprocessor channels raise inputs
// - fpu flags feed inputs, twelve-bit request
// - timers and nmi bypass the expander
// - all eight conversion-done irqs reach expander
package pix_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int NGRP = 12;
    localparam int NPOS = 8;
    localparam int NSRC = 96;
    localparam int VEC_W = 22;
    localparam int IDX_W = 7;
    // vector table byte window, two address units per word
    localparam logic [15:0] VEC_BASE = 16'h0D40;
    localparam logic [15:0] VEC_LAST = 16'h0DFE;
    // cycles from fetch request to the done state; the vector is returned one cycle later
    localparam int FETCH_CYC = 8;
    localparam logic [3:0] FETCH_LAST = 4'(FETCH_CYC - 1);
    // wired positions; one bit per input, group 1 in low byte
    localparam logic [95:0] WIRED_MASK = {
        8'hFB, 8'h0F, 8'hFF, 8'h03, 8'h03, 8'h3F,
        8'h33, 8'h87, 8'hBF, 8'hFF, 8'hFF, 8'hDB};
    // slot index of named sources (group-1)*8 + (pos-1)
    localparam int SLOT_CONV_FIRST = 72;
    localparam int SLOT_DMA_FIRST = 48;
    localparam int SLOT_IPC_FIRST = 80;
    localparam int SLOT_FLASH_ERR = 89;
    localparam int SLOT_RAM_ERR = 91;
    localparam int SLOT_FPU_OVF = 94;
    localparam int SLOT_FPU_UNF = 95;

    typedef enum logic [1:0] {
        PIX_IDLE = 2'b00,
        PIX_WAIT = 2'b01,
        PIX_DONE = 2'b10
    } pix_fetch_t;

    // byte address of the vector word for a slot
    function automatic logic [15:0] pix_vec_addr(input logic [6:0] idx);
        pix_vec_addr = VEC_BASE + {8'h00, idx, 1'b0};
    endfunction
endpackage

//--- pix_if.sv
interface pix_if;
    import pix_pkg::*;
    // twelve group lines toward the core
    logic [NGRP-1:0] group_request_vector;
    // fetch handshake: core asks for the vector of a line
    logic fetch_req;
    logic [3:0] fetch_grp;
    logic fetch_ack;
    logic [IDX_W-1:0] fetch_idx;
    logic [VEC_W-1:0] fetch_vec;
    // software side: enables, flags, vector writes, group ack
    logic [NSRC-1:0] sw_enable;
    logic sw_flag_set;
    logic [IDX_W-1:0] sw_flag_idx;
    logic vec_wr;
    logic [IDX_W-1:0] vec_wr_idx;
    logic [VEC_W-1:0] vec_wr_data;
    logic [NGRP-1:0] grp_ack;
    modport expander (
        output group_request_vector, fetch_ack, fetch_idx, fetch_vec,
        input fetch_req, fetch_grp, sw_enable, sw_flag_set, sw_flag_idx,
        input vec_wr, vec_wr_idx, vec_wr_data, grp_ack);
    modport core (
        input group_request_vector, fetch_ack, fetch_idx, fetch_vec,
        output fetch_req, fetch_grp, sw_enable, sw_flag_set, sw_flag_idx,
        output vec_wr, vec_wr_idx, vec_wr_data, grp_ack);
endinterface

//--- pix_core_end.sv
module pix_core_end
    import pix_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // link to the expander
    pix_if.core link,
    // user side: masks and software actions
    input wire logic [NGRP-1:0] cpu_mask,
    input wire logic [NSRC-1:0] enable_in,
    input wire logic swi_req,
    input wire logic [IDX_W-1:0] swi_idx,
    input wire logic vwr,
    input wire logic [IDX_W-1:0] vwr_idx,
    input wire logic [VEC_W-1:0] vwr_data,
    input wire logic [NGRP-1:0] ack_in,
    // serviced vector
    output logic vec_valid,
    output logic [IDX_W-1:0] vec_idx,
    output logic [VEC_W-1:0] vec_out
);
    import pix_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic wait_f;            // fetch outstanding
        logic req;
        logic [3:0] grp;
        logic [NSRC-1:0] en;
        logic swi;
        logic [IDX_W-1:0] swi_i;
        logic vwr;
        logic [IDX_W-1:0] vwr_i;
        logic [VEC_W-1:0] vwr_d;
        logic [NGRP-1:0] ack;
        logic vv;
        logic [IDX_W-1:0] vi;
        logic [VEC_W-1:0] vd;
    } pix_core_t;

    pix_core_t st_r;
    pix_core_t st_nxt;

    // software actions, lowest unmasked line first
    always_comb begin
        logic [NGRP-1:0] act;
        st_nxt = st_r;
        act = link.group_request_vector & cpu_mask;
        st_nxt.req = 1'b0;
        st_nxt.vv = 1'b0;
        st_nxt.en = enable_in;
        // swi set is a single-bit set, no read-modify-write
        st_nxt.swi = swi_req;
        st_nxt.swi_i = swi_idx;
        st_nxt.vwr = vwr;
        st_nxt.vwr_i = vwr_idx;
        st_nxt.vwr_d = vwr_data;
        st_nxt.ack = ack_in;
        if (!st_r.wait_f && !st_r.req && act != '0) begin
            for (int g = NGRP - 1; g >= 0; g--) begin
                if (act[g]) begin
                    st_nxt.grp = 4'(g);
                end
            end
            st_nxt.req = 1'b1;
            st_nxt.wait_f = 1'b1;
        end
        // a refused request leaves no ack; retry on next idle cycle
        if (st_r.req && act == '0) begin
            st_nxt.wait_f = 1'b0;
        end
        if (link.fetch_ack) begin
            st_nxt.wait_f = 1'b0;
            st_nxt.vv = 1'b1;
            st_nxt.vi = link.fetch_idx;
            st_nxt.vd = link.fetch_vec;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.fetch_req = st_r.req;
    assign link.fetch_grp = st_r.grp;
    assign link.sw_enable = st_r.en;
    assign link.sw_flag_set = st_r.swi;
    assign link.sw_flag_idx = st_r.swi_i;
    assign link.vec_wr = st_r.vwr;
    assign link.vec_wr_idx = st_r.vwr_i;
    assign link.vec_wr_data = st_r.vwr_d;
    assign link.grp_ack = st_r.ack;
    assign vec_valid = st_r.vv;
    assign vec_idx = st_r.vi;
    assign vec_out = st_r.vd;
endmodule

//--- pix_monitor.sv
module pix_monitor
    import pix_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // link signals
    input wire logic [NGRP-1:0] group_request_vector,
    input wire logic fetch_req,
    input wire logic [3:0] fetch_grp,
    input wire logic fetch_ack,
    input wire logic [IDX_W-1:0] fetch_idx,
    input wire logic [NSRC-1:0] sw_enable,
    input wire logic sw_flag_set,
    input wire logic [NGRP-1:0] grp_ack
);
    // ****
    // checks
    // ****
    logic [NGRP-1:0] en_any; // group has any enabled slot
    // or-reduce each group's enables
    always_comb begin
        for (int g = 0; g < NGRP; g++) begin
            en_any[g] = |sw_enable[g*8+:8];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    ack_latency_a: assert property (fetch_ack |-> $past(fetch_req, 9))
        else $error("answer not nine cycles after request");
    ack_group_a: assert property (
        fetch_ack |-> fetch_idx[6:3] == $past(fetch_grp, 9))
        else $error("answered slot outside requested group");
    line_low_a: assert property (
        fetch_ack |-> !group_request_vector[fetch_idx[6:3]])
        else $error("group line high during its fetch");
    still_blocked_a: assert property (
        fetch_ack |=> !group_request_vector[$past(fetch_idx[6:3])])
        else $error("group line reopened without group ack");
    ack_spacing_a: assert property (fetch_ack |=> !fetch_ack [*8])
        else $error("answers closer than one fetch apart");
    line_enabled_a: assert property (
        (group_request_vector & ~en_any & ~$past(en_any)) == '0)
        else $error("line raised with every slot disabled");
    slot_enabled_a: assert property (fetch_ack |-> sw_enable[fetch_idx])
        else $error("disabled slot answered");
    idx_range_a: assert property (fetch_ack |-> fetch_idx < 7'h60)
        else $error("answered slot beyond the last vector");
    // main traffic seen at all
    cover property (fetch_ack);
    cover property (sw_flag_set);
    cover property (|grp_ack);
endmodule

//--- tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // signals
    // ****
    // wired slots, group 1 in the low byte
    localparam logic [95:0] WIRED = {8'hFB, 8'h0F, 8'hFF, 8'h03,
        8'h03, 8'h3F, 8'h33, 8'h87, 8'hBF, 8'hFF, 8'hFF, 8'hDB};
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [95:0] src = '0; // every source, by slot
    logic [95:0] en = '0;
    logic [11:0] mask = '0; // 1 lets a line through
    logic [11:0] ack = '0;
    logic swi = 1'h0;
    logic [6:0] swi_i = '0;
    logic vw = 1'h0;
    logic [6:0] vw_i = '0;
    logic [21:0] vw_d = '0;
    logic [2:0] byp_in = '0; // timer one, timer two, nmi
    logic [2:0] byp_out;
    logic vv;
    logic [6:0] vi;
    logic [21:0] vo;
    logic [21:0] vt [96]; // vector written per slot
    logic [6:0] exp_q [$]; // slots owed, in order
    logic [6:0] e;
    logic on = 1'h0; // bypass checks armed
    int a;
    int b;
    int err_count = 0;
    int comparisons = 0;
    pix_if link ();
    pix_core_end i_pix_core_end (.sys_clk, .rst_b, .link(link),
        .cpu_mask(mask), .enable_in(en), .swi_req(swi), .swi_idx(swi_i),
        .vwr(vw), .vwr_idx(vw_i), .vwr_data(vw_d), .ack_in(ack),
        .vec_valid(vv), .vec_idx(vi), .vec_out(vo));
    pix_expander i_pix_expander (.sys_clk, .rst_b, .link(link),
        .conversion_done_irq(src[79:72]), .dma_channel_irq(src[53:48]),
        .interproc_channel_irq(src[83:80]),
        .ram_single_error_irq(src[91]), .flash_single_error_irq(src[89]),
        .fpu_overflow_flag(src[94]), .fpu_underflow_flag(src[95]),
        .other_irq(src), .timer_one_irq(byp_in[0]),
        .timer_two_irq(byp_in[1]), .direct_nmi_irq(byp_in[2]),
        .timer_one_out(byp_out[0]), .timer_two_out(byp_out[1]),
        .direct_nmi_out(byp_out[2]));
    pix_monitor i_pix_monitor (.sys_clk, .rst_b,
        .group_request_vector(link.group_request_vector),
        .fetch_req(link.fetch_req), .fetch_grp(link.fetch_grp),
        .fetch_ack(link.fetch_ack), .fetch_idx(link.fetch_idx),
        .sw_enable(link.sw_enable), .sw_flag_set(link.sw_flag_set),
        .grp_ack(link.grp_ack));
    always #12.5 sys_clk = ~sys_clk;
    // ****
    // tasks
    // ****
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic cmp_vec(input logic [28:0] x, input logic [28:0] g);
        comparisons++;
        if (x !== g) begin
            err_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask
    task automatic cmp_byp(input logic [2:0] x, input logic [2:0] g);
        cmp_vec({26'h0, x}, {26'h0, g});
    endtask
    // bounded wait until at most n slots are owed
    task automatic wait_q(input int n);
        for (int i = 0; i < 80 && exp_q.size() > n; i++)
            tick(1);
        cmp_vec(29'(n), 29'(exp_q.size() > n ? exp_q.size() : n));
    endtask
    // one-cycle pulse; levels would keep flags set
    task automatic pulse(input logic [95:0] s);
        src = s;
        tick(1);
        src = '0;
        tick(20);
    endtask
    task automatic ack_grp(input int g);
        ack[g] = 1'h1;
        tick(1);
        ack = '0;
        tick(3);
    endtask
    task automatic finish_test();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****
    // stimulus and checking
    // ****
    // bypass inputs change by nba, so the old value is read here
    always @(negedge sys_clk) begin
        byp_in <= 3'($urandom);
        if (on) cmp_byp(byp_in, byp_out);
        if (vv === 1'h1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("ERROR t=%0t exp=none got=%h", $time, vi);
            end else begin
                e = exp_q.pop_front();
                cmp_vec({e, vt[e]}, {vi, vo});
            end
        end
    end
    initial begin
        void'($urandom(84735));
        tick(11);
        rst_b = 1'h1;
        tick(2);
        on = 1'h1;
        // vector ram is not reset, so fill it first
        for (int i = 0; i < 96; i++) begin
            vw = 1'h1;
            vw_i = 7'(i);
            vw_d = 22'($urandom);
            vt[i] = vw_d;
            tick(1);
        end
        vw = 1'h0;
        en = '1;
        mask = '1;
        tick(3);
        // each slot alone; unwired ones stay silent
        for (int s = 0; s < 96; s++) begin
            if (WIRED[s]) exp_q.push_back(7'(s));
            pulse(96'h1 << s);
            wait_q(0);
            ack_grp(s / 8);
        end
        // eight pending in one group, served in position order
        for (int k = 8; k < 16; k++) exp_q.push_back(7'(k));
        pulse({80'h0, 8'hFF, 8'h0});
        for (int k = 7; k >= 0; k--) begin
            wait_q(k);
            ack_grp(1);
        end
        // random pairs, the lower slot first
        for (int p = 0; p < 16; p++) begin
            do a = $urandom % 96; while (!WIRED[a]);
            do b = $urandom % 96; while (!WIRED[b] || b == a);
            if (b < a) {a, b} = {b, a};
            exp_q.push_back(7'(a));
            exp_q.push_back(7'(b));
            pulse((96'h1 << a) | (96'h1 << b));
            wait_q(1);
            ack_grp(a / 8);
            wait_q(0);
            ack_grp(b / 8);
        end
        // software requests on reserved slots of an empty group
        for (int s = 84; s < 88; s++) begin
            swi = 1'h1;
            swi_i = 7'(s);
            exp_q.push_back(7'(s));
            tick(1);
            swi = 1'h0;
            wait_q(0);
            ack_grp(10);
        end
        // a masked line keeps its request until unmasked
        mask[3] = 1'h0;
        pulse(96'h1 << 24);
        tick(20);
        exp_q.push_back(7'd24);
        mask = '1;
        wait_q(0);
        ack_grp(3);
        // a disabled slot never reaches its line
        en[0] = 1'h0;
        pulse(96'h1);
        tick(20);
        finish_test();
    end
    // about 3500 cycles expected; cut off well past that
    initial begin
        #600000;
        err_count++;
        finish_test();
    end
endmodule
